// *** acsr_defs.svh ***
// Register offsets, field positions, reset values and counts for the config bank
`ifndef ACSR_DEFS_SVH
`define ACSR_DEFS_SVH
`define ACSR_ADDR_W 15
`define ACSR_ADDR_MAKER_HI 15'h000d
`define ACSR_ADDR_LOOP_LEN 15'h000e
`define ACSR_ADDR_IFC_THIRD 15'h0010
`define ACSR_ADDR_ERR_STAT 15'h0011
`define ACSR_ADDR_LEAVE 15'h0014
`define ACSR_ADDR_AVG_CTRL 15'h0015
`define ACSR_ADDR_TOP 15'h7fff
`define ACSR_ERR_CLKCNT_BIT 4
`define ACSR_LEAVE_BIT 0
`define ACSR_RESTART_BIT 7
`define ACSR_EXP_MSB 4
`define ACSR_EXP_W 5
`define ACSR_RST_BYTE 8'h00
`define ACSR_RST_EXP 5'h00
`define ACSR_INSTR_LAST 5'h0f
`define ACSR_BYTE_LAST 5'h07
`endif

// *** acsr_pkg.sv ***
// Types shared by the config register bank
package acsr_pkg;
  typedef enum logic [1:0] {
    ACSR_IDLE = 2'b00,
    ACSR_INSTR = 2'b01,
    ACSR_DATA = 2'b11
  } acsr_state_t;
  typedef logic [14:0] acsr_addr_t;
endpackage : acsr_pkg

// *** acsr_sync_edge.sv ***
// Two-flop pin synchroniser with edge detection
`timescale 1ns/10ps
`default_nettype none
module acsr_sync_edge #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;
  logic [2:0] pipe_next;

  always_comb begin
    pipe_next = {meta_reg, sync_reg, pin};
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
      last_reg <= RST_VAL;
    end else begin
      meta_reg <= pipe_next[0];
      sync_reg <= pipe_next[2];
      last_reg <= pipe_next[1];
    end
  end

  assign level = sync_reg;
  assign rise = sync_reg & ~last_reg;
  assign fall = ~sync_reg & last_reg;
endmodule : acsr_sync_edge
`default_nettype wire

// *** acsr_regs.sv ***
// Serial config register bank: identification, streaming loop, status, exit, averaging
`include "acsr_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module acsr_regs
  import acsr_pkg::*;
#(
  parameter logic [7:0] MAKER_ID_HIGH = 8'h5a // Arbitrary value
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic SCK,
  input wire logic CS_N,
  input wire logic SDI,
  input wire logic ONE_INSTRUCTION_SELECT,
  output logic SDO,
  output logic SDO_OE,
  output logic CONFIG_EXIT,
  output logic FILTER_RESTART,
  output logic [4:0] FILTER_BLOCK_EXPONENT,
  output logic AVERAGING_ENABLE
);
  logic sck_rise, sck_fall, cs_lvl, cs_rise, cs_fall, sdi_lvl;
  logic single_lvl;

  acsr_sync_edge #(.RST_VAL(1'b0)) u_sck (.clk(CLK), .rstn(RSTN), .pin(SCK),
    .level(), .rise(sck_rise), .fall(sck_fall));
  acsr_sync_edge #(.RST_VAL(1'b1)) u_cs (.clk(CLK), .rstn(RSTN), .pin(CS_N),
    .level(cs_lvl), .rise(cs_rise), .fall(cs_fall));
  acsr_sync_edge #(.RST_VAL(1'b0)) u_sdi (.clk(CLK), .rstn(RSTN), .pin(SDI),
    .level(sdi_lvl), .rise(), .fall());
  acsr_sync_edge #(.RST_VAL(1'b0)) u_single (.clk(CLK), .rstn(RSTN),
    .pin(ONE_INSTRUCTION_SELECT), .level(single_lvl), .rise(), .fall());

  acsr_state_t state_reg, state_next;
  logic [4:0] bit_reg, bit_next;
  logic [14:0] in_reg, in_next;
  logic [7:0] out_reg, out_next;
  logic sdo_reg, sdo_next;
  logic rd_reg, rd_next;
  logic seen_reg, seen_next;
  acsr_addr_t addr_reg, addr_next, start_reg, start_next;
  logic [7:0] loop_reg, loop_next, loop_cur_reg, loop_cur_next, lcnt_reg, lcnt_next;
  logic loop_wr_reg, loop_wr_next;
  logic err_reg, err_next;
  logic leave_reg, leave_next;
  logic exit_reg, exit_next;
  logic restart_reg, restart_next;
  logic [4:0] exp_reg, exp_next;
  logic [15:0] word;
  logic byte_done, loop_hit, err_set;
  acsr_addr_t step_addr;

  function automatic logic [7:0] read_byte(input acsr_addr_t a);
    logic [7:0] d;
    d = 8'h00;
    unique case (a)
      `ACSR_ADDR_MAKER_HI: d = MAKER_ID_HIGH;
      `ACSR_ADDR_LOOP_LEN: d = loop_reg;
      `ACSR_ADDR_ERR_STAT: d[`ACSR_ERR_CLKCNT_BIT] = err_reg;
      `ACSR_ADDR_LEAVE: d[`ACSR_LEAVE_BIT] = leave_reg;
      `ACSR_ADDR_AVG_CTRL: d = {restart_reg, 2'b00, exp_reg};
      default: d = 8'h00;
    endcase
    return d;
  endfunction : read_byte

  always_comb begin
    word = {in_reg[14:0], sdi_lvl};
    byte_done = (state_reg == ACSR_DATA) && sck_rise && (bit_reg == `ACSR_BYTE_LAST);
    loop_hit = (loop_cur_reg != 8'h00) && (8'(lcnt_reg + 8'h01) == loop_cur_reg);
    step_addr = loop_hit ? start_reg : acsr_addr_t'(addr_reg - 15'h0001);
    err_set = cs_rise && !((state_reg == ACSR_DATA) && (bit_reg == 5'h00) && seen_reg);
  end

  always_comb begin
    state_next = state_reg;
    bit_next = bit_reg;
    in_next = in_reg;
    out_next = out_reg;
    sdo_next = sdo_reg;
    rd_next = rd_reg;
    seen_next = seen_reg;
    addr_next = addr_reg;
    start_next = start_reg;
    loop_next = loop_reg;
    loop_cur_next = loop_cur_reg;
    lcnt_next = lcnt_reg;
    loop_wr_next = loop_wr_reg;
    leave_next = leave_reg;
    exit_next = 1'b0;
    restart_next = 1'b0;
    exp_next = exp_reg;
    if (cs_rise) begin
      state_next = ACSR_IDLE;
      sdo_next = 1'b0;
      loop_wr_next = 1'b0;
      if (!loop_wr_reg) begin
        loop_next = `ACSR_RST_BYTE;
      end
      if (leave_reg) begin
        leave_next = 1'b0;
        exit_next = 1'b1;
      end
    end else if (cs_fall) begin
      state_next = ACSR_INSTR;
      bit_next = 5'h00;
      seen_next = 1'b0;
      lcnt_next = 8'h00;
      loop_cur_next = loop_reg;
    end else if (sck_rise && state_reg != ACSR_IDLE) begin
      in_next = word[14:0];
      bit_next = 5'(bit_reg + 5'h01);
      if (state_reg == ACSR_INSTR && bit_reg == `ACSR_INSTR_LAST) begin
        state_next = ACSR_DATA;
        bit_next = 5'h00;
        rd_next = word[15];
        addr_next = word[14:0];
        start_next = word[14:0];
        out_next = read_byte(word[14:0]);
      end else if (byte_done) begin
        bit_next = 5'h00;
        seen_next = 1'b1;
        if (!rd_reg && !(single_lvl && seen_reg)) begin
          unique case (addr_reg)
            `ACSR_ADDR_LOOP_LEN: begin
              loop_next = word[7:0];
              loop_wr_next = 1'b1;
            end
            `ACSR_ADDR_LEAVE: leave_next = word[`ACSR_LEAVE_BIT];
            `ACSR_ADDR_AVG_CTRL: begin
              restart_next = word[`ACSR_RESTART_BIT];
              exp_next = word[`ACSR_EXP_MSB:0];
            end
            default: ;
          endcase
        end
        if (!single_lvl) begin
          addr_next = step_addr;
          lcnt_next = loop_hit ? 8'h00 : 8'(lcnt_reg + 8'h01);
          out_next = read_byte(step_addr);
        end else begin
          out_next = read_byte(addr_reg);
        end
      end
    end else if (sck_fall && state_reg == ACSR_DATA) begin
      sdo_next = rd_reg & out_reg[7];
      out_next = {out_reg[6:0], 1'b0};
    end
  end

  // Flag clear from a status write, kept apart so a same-cycle set wins
  logic w1c_hit;
  always_comb begin
    w1c_hit = byte_done && !rd_reg && !(single_lvl && seen_reg) &&
      (addr_reg == `ACSR_ADDR_ERR_STAT) && word[`ACSR_ERR_CLKCNT_BIT];
    err_next = (err_reg & ~w1c_hit) | err_set;
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_reg <= ACSR_IDLE;
      bit_reg <= 5'h00;
      in_reg <= 15'h0000;
      out_reg <= `ACSR_RST_BYTE;
      sdo_reg <= 1'b0;
      rd_reg <= 1'b0;
      seen_reg <= 1'b0;
      addr_reg <= 15'h0000;
      start_reg <= 15'h0000;
      loop_reg <= `ACSR_RST_BYTE;
      loop_cur_reg <= `ACSR_RST_BYTE;
      lcnt_reg <= 8'h00;
      loop_wr_reg <= 1'b0;
      err_reg <= 1'b0;
      leave_reg <= 1'b0;
      exit_reg <= 1'b0;
      restart_reg <= 1'b0;
      exp_reg <= `ACSR_RST_EXP;
    end else begin
      state_reg <= state_next;
      bit_reg <= bit_next;
      in_reg <= in_next;
      out_reg <= out_next;
      sdo_reg <= sdo_next;
      rd_reg <= rd_next;
      seen_reg <= seen_next;
      addr_reg <= addr_next;
      start_reg <= start_next;
      loop_reg <= loop_next;
      loop_cur_reg <= loop_cur_next;
      lcnt_reg <= lcnt_next;
      loop_wr_reg <= loop_wr_next;
      err_reg <= err_next;
      leave_reg <= leave_next;
      exit_reg <= exit_next;
      restart_reg <= restart_next;
      exp_reg <= exp_next;
    end
  end

  assign SDO = sdo_reg;
  assign SDO_OE = ~cs_lvl;
  assign CONFIG_EXIT = exit_reg;
  assign FILTER_RESTART = restart_reg;
  assign FILTER_BLOCK_EXPONENT = exp_reg;
  assign AVERAGING_ENABLE = (exp_reg != 5'h00);

  logic instr_end;
  assign instr_end = sck_rise && (state_reg == ACSR_INSTR) && (bit_reg == `ACSR_INSTR_LAST);

  sequence s_exit_armed;
    leave_reg && !cs_rise;
  endsequence
  sequence s_frame_close;
    cs_rise && leave_reg;
  endsequence

  a_maker_id_read: assert property (@(posedge CLK) disable iff (!RSTN)
    instr_end && word[14:0] == `ACSR_ADDR_MAKER_HI |=> out_reg == MAKER_ID_HIGH)
    else $error("maker id byte not loaded");
  a_loop_return: assert property (@(posedge CLK) disable iff (!RSTN)
    byte_done && !cs_rise && !single_lvl && loop_hit |=> addr_reg == $past(start_reg))
    else $error("loop did not return to start");
  a_addr_wrap: assert property (@(posedge CLK) disable iff (!RSTN)
    byte_done && !cs_rise && !single_lvl && loop_cur_reg == 8'h00 && addr_reg == 15'h0000
    |=> addr_reg == `ACSR_ADDR_TOP)
    else $error("address did not wrap at lower limit");
  a_loop_autoclear: assert property (@(posedge CLK) disable iff (!RSTN)
    cs_rise && !loop_wr_reg |=> loop_reg == 8'h00 && !loop_wr_reg)
    else $error("loop length not cleared at frame end");
  a_status_clear: assert property (@(posedge CLK) disable iff (!RSTN)
    w1c_hit && !err_set |=> !err_reg ##1 (err_reg == $past(err_set)))
    else $error("status flag not cleared by write of one");
  a_clock_count: assert property (@(posedge CLK) disable iff (!RSTN)
    cs_rise && state_reg == ACSR_INSTR |=> err_reg)
    else $error("short frame did not flag clock count error");
  a_exit_selfclr: assert property (@(posedge CLK) disable iff (!RSTN)
    s_frame_close |=> !leave_reg && CONFIG_EXIT ##1 !CONFIG_EXIT)
    else $error("exit bit not self cleared at chip select high");
  a_exit_hold: assert property (@(posedge CLK) disable iff (!RSTN)
    s_exit_armed ##1 !cs_rise |-> leave_reg || $past(byte_done))
    else $error("exit bit lost before frame end");
  a_restart_pulse: assert property (@(posedge CLK) disable iff (!RSTN)
    restart_reg |=> !restart_reg && FILTER_RESTART == 1'b0)
    else $error("filter restart not self clearing");
  a_addr_decrement: assert property (@(posedge CLK) disable iff (!RSTN)
    byte_done && !cs_rise && !single_lvl && !loop_hit
    |=> addr_reg == acsr_addr_t'($past(addr_reg) - 15'h0001))
    else $error("streaming address not decremented");
  a_reserved_zero: assert property (@(posedge CLK) disable iff (!RSTN)
    instr_end && word[14:0] == `ACSR_ADDR_IFC_THIRD |=> out_reg == 8'h00)
    else $error("reserved register read nonzero");
endmodule : acsr_regs
`default_nettype wire

// *** acsr_host.sv ***
// Host-side serial controller model for the config register bank
`timescale 1ns/10ps
`default_nettype none
module acsr_host (
  input wire logic clk,
  output logic sck,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tick
  // Mode 0 frame: data moves with SCK low, sampled on each rise
  task automatic frame(input logic [15:0] ins, input logic [63:0] wd, input int nr,
                       output logic [63:0] rd);
    logic [79:0] sh;
    sh = {ins, wd};
    rd = '0;
    tick(1);
    cs_n = 1'b0;
    for (int i = 0; i < nr; i++) begin
      sdi = sh[79 - i];
      tick(4);
      sck = 1'b1;
      if (i >= 16) rd = {rd[62:0], sdo};
      tick(4);
      sck = 1'b0;
    end
    tick(4);
    cs_n = 1'b1;
    sdi = ~sdi; // Released line shows no stale value
    tick(8);
  endtask : frame
endmodule : acsr_host
`default_nettype wire

// *** acsr_regs_tb.sv ***
// Self-checking bench for the config register bank
`include "acsr_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module acsr_regs_tb;
  import acsr_pkg::*;
  localparam logic [7:0] ID_HI = 8'h3c; // Arbitrary value
  logic CLK = 1'b0;
  logic RSTN = 1'b0;
  logic ONE_INSTRUCTION_SELECT = 1'b0;
  logic SCK, CS_N, SDI, SDO, SDO_OE, CONFIG_EXIT, FILTER_RESTART, AVERAGING_ENABLE;
  logic [4:0] FILTER_BLOCK_EXPONENT;
  logic [31:0] seed = 32'h0000005d;
  logic [63:0] rd;
  int num_errors = 0;
  int check_count = 0;
  int exits = 0;
  int restarts = 0;
  always #12.5 CLK = ~CLK;
  always @(posedge CLK) begin
    if (CONFIG_EXIT === 1'b1) exits <= exits + 1;
    if (FILTER_RESTART === 1'b1) restarts <= restarts + 1;
  end
  acsr_regs #(.MAKER_ID_HIGH(ID_HI)) u_acsr_regs (.CLK(CLK), .RSTN(RSTN), .SCK(SCK),
    .CS_N(CS_N), .SDI(SDI), .ONE_INSTRUCTION_SELECT(ONE_INSTRUCTION_SELECT), .SDO(SDO),
    .SDO_OE(SDO_OE), .CONFIG_EXIT(CONFIG_EXIT), .FILTER_RESTART(FILTER_RESTART),
    .FILTER_BLOCK_EXPONENT(FILTER_BLOCK_EXPONENT), .AVERAGING_ENABLE(AVERAGING_ENABLE));
  acsr_host u_acsr_host (.clk(CLK), .sck(SCK), .cs_n(CS_N), .sdi(SDI), .sdo(SDO));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  function automatic logic [7:0] avg_rb(input logic [7:0] w);
    return {3'b000, w[4:0]};
  endfunction : avg_rb
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    u_acsr_host.frame({1'b0, a}, {d, 56'h0}, 24, rd);
  endtask : wr
  task automatic rchk(input string nm, input logic [14:0] a, input logic [7:0] e);
    u_acsr_host.frame({1'b1, a}, 64'h0, 24, rd);
    chk(nm, e, rd[7:0]);
  endtask : rchk
  task automatic end_sim();
    if (num_errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim
  initial begin
    repeat (100000) @(posedge CLK);
    num_errors++;
    end_sim();
  end
  initial begin
    logic [31:0] r;
    logic [7:0] w;
    int r0;
    repeat (12) @(posedge CLK);
    #2;
    RSTN = 1'b1;
    chk("exponent", 8'h00, {3'b000, FILTER_BLOCK_EXPONENT});
    chk("enable", 8'h00, {7'h00, AVERAGING_ENABLE});
    // Output enable stands for the whole frame and drops after it
    fork
      rchk("maker_hi", `ACSR_ADDR_MAKER_HI, ID_HI);
      begin
        repeat (20) @(posedge CLK);
        #2;
        chk("oe_busy", 8'h01, {7'h00, SDO_OE});
      end
    join
    chk("oe_idle", 8'h00, {7'h00, SDO_OE});
    wr(`ACSR_ADDR_MAKER_HI, ~ID_HI);
    rchk("maker_hi_ro", `ACSR_ADDR_MAKER_HI, ID_HI);
    wr(`ACSR_ADDR_IFC_THIRD, 8'hff);
    rchk("ifc_third", `ACSR_ADDR_IFC_THIRD, 8'h00);
    rchk("unmapped", 15'h000f, 8'h00);
    // Every legal block code with random restart and reserved bits
    for (int c = 0; c <= 16; c++) begin
      r = xs();
      w = {r[7:5], c[4:0]};
      r0 = restarts;
      wr(`ACSR_ADDR_AVG_CTRL, w);
      chk("exponent", {3'b000, c[4:0]}, {3'b000, FILTER_BLOCK_EXPONENT});
      chk("enable", {7'h00, c != 0}, {7'h00, AVERAGING_ENABLE});
      chk("restart", {7'h00, w[7]}, 8'(restarts - r0));
      rchk("avg_rb", `ACSR_ADDR_AVG_CTRL, avg_rb(w));
    end
    u_acsr_host.frame(16'h8011, 64'h0, 20, rd);
    rchk("err_set", `ACSR_ADDR_ERR_STAT, 8'h10);
    wr(`ACSR_ADDR_ERR_STAT, 8'hef);
    rchk("err_keep", `ACSR_ADDR_ERR_STAT, 8'h10);
    wr(`ACSR_ADDR_ERR_STAT, 8'h10);
    rchk("err_clr", `ACSR_ADDR_ERR_STAT, 8'h00);
    u_acsr_host.frame(16'h0011, 64'h0, 0, rd);
    rchk("err_zero", `ACSR_ADDR_ERR_STAT, 8'h10);
    wr(`ACSR_ADDR_ERR_STAT, 8'hff);
    r0 = exits;
    wr(`ACSR_ADDR_LEAVE, 8'h01);
    chk("exit_pulse", 8'h01, 8'(exits - r0));
    rchk("leave_rb", `ACSR_ADDR_LEAVE, 8'h00);
    // Loop of two bytes applies to the following frame only
    wr(`ACSR_ADDR_LOOP_LEN, 8'h02);
    u_acsr_host.frame({1'b0, `ACSR_ADDR_AVG_CTRL}, 64'h0300_0500_0000_0000, 48, rd);
    chk("loop_exp", 8'h05, {3'b000, FILTER_BLOCK_EXPONENT});
    rchk("loop_clr", `ACSR_ADDR_LOOP_LEN, 8'h00);
    u_acsr_host.frame({1'b1, `ACSR_ADDR_AVG_CTRL}, 64'h0, 48, rd);
    chk("stream0", 8'h05, rd[31:24]);
    chk("stream2", 8'h00, rd[15:8]);
    // Streaming read from the lowest address wraps to the top of the space
    u_acsr_host.frame(16'h8000, 64'h0, 32, rd);
    chk("wrap_low", 8'h00, rd[15:8]);
    chk("wrap_top", 8'h00, rd[7:0]);
    ONE_INSTRUCTION_SELECT = 1'b1;
    u_acsr_host.frame({1'b0, `ACSR_ADDR_AVG_CTRL}, 64'h0709_0000_0000_0000, 32, rd);
    chk("single", 8'h07, {3'b000, FILTER_BLOCK_EXPONENT});
    // Single instruction read repeats the same address
    u_acsr_host.frame({1'b1, `ACSR_ADDR_AVG_CTRL}, 64'h0, 32, rd);
    chk("single_rd0", 8'h07, rd[15:8]);
    chk("single_rd1", 8'h07, rd[7:0]);
    ONE_INSTRUCTION_SELECT = 1'b0;
    end_sim();
  end
endmodule : acsr_regs_tb
`default_nettype wire
